// >>> verilog/rmo_regs.sv
// Radio manual override and test register bank with APB slave
//
// How it works
// - Low-byte bits 6..0 power down cal osc, pump, synth, ADC, VGA, filter, front end.
// - Low-byte bit 0 powers down LNA, down-mixers and front-end bias.
// - High-byte bit 7 is VGA peak reset (low), bit 3 prescaler, bit 0 DACs.
// - High-byte bit 6 is global bias power-down, 1 means off.
// - High-byte bit 5 steers output switch; 1 gives PA external bias.
// - High-byte bit 4 picks LO buffers (0) or PA buffers (1).
// - Bits 2,1 power down PA paths; both set also stops up-mixers.
// - Gain override enable makes RX use manual VGA gain over AGC.
// - VGA gain field stores manual value, reads gain in use, resets all ones.
// - Gain-mode override: 00 AGC, 01 low, 10 medium, 11 high.
// - Read-only gain-mode status shows the mode actually in effect.
// - Read-only 6-bit field shows frame-control state, no reset value.
// - Clock-gate bit 7 of the ADC I register, set to 1, stops ADC clock even when ADC is enabled.
// - Two read-only 7-bit fields return live ADC I and Q samples.
// - 3-bit DAC source field selects one of eight TX DAC sources.
// - Source 001 drives DACs from override values; I upper bits at 3:0.
// - Reserved bits ignore writes and read as zero.
// - Next register holds I low bits 7:6 and Q bits 5:0, reset zero.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "rmo_defs.svh"

module rmo_regs #(
    parameter int ADDR_W = 18
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  ce_in,
    // APB slave
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [ADDR_W-1:0]     paddr_in,
    input  wire logic [31:0]           pwdata_in,
    input  wire logic [3:0]            pstrb_in,
    output logic                       pready_out,
    output logic [31:0]                prdata_out,
    output logic                       pslverr_out,
    // Internally generated analog controls
    input  wire logic [7:0]            ctl_high_in,
    input  wire logic [6:0]            ctl_low_in,
    input  wire logic [6:0]            agc_vga_gain_in,
    input  wire logic [1:0]            agc_gain_mode_in,
    input  wire logic [5:0]            frame_fsm_state_in,
    // Live ADC samples, from the analog side
    input  wire logic [6:0]            adc_i_in,
    input  wire logic [6:0]            adc_q_in,
    // Candidate TX DAC sources
    input  wire logic [5:0]            mod_i_in,
    input  wire logic [5:0]            mod_q_in,
    input  wire logic [5:0]            filt_i_in,
    input  wire logic [5:0]            filt_q_in,
    input  wire logic [5:0]            noise_i_in,
    input  wire logic [5:0]            noise_q_in,
    input  wire logic [5:0]            rssi_mag_in,
    input  wire logic [5:0]            debug_i_in,
    input  wire logic [5:0]            debug_q_in,
    // Effective analog controls
    output logic                       filter_cal_osc_powerdown_out,
    output logic                       charge_pump_powerdown_out,
    output logic                       synth_chain_powerdown_out,
    output logic                       adc_powerdown_out,
    output logic                       vga_powerdown_out,
    output logic                       rx_filter_powerdown_out,
    output logic                       front_end_powerdown_out,
    output logic                       vga_peak_reset_n_out,
    output logic                       global_bias_powerdown_out,
    output logic                       output_switch_bias_ctl_out,
    output logic                       buffer_select_out,
    output logic                       prescaler_powerdown_out,
    output logic                       amp_neg_path_powerdown_out,
    output logic                       amp_pos_path_powerdown_out,
    output logic                       up_mixer_powerdown_out,
    output logic                       tx_dac_powerdown_out,
    // Gain, clock and DAC outputs
    output logic [6:0]                 vga_gain_out,
    output rmo_pkg::rmo_gain_mode_t    gain_mode_out,
    output logic                       adc_clk_en_out,
    output rmo_pkg::rmo_dac_sel_t      dac_source_out,
    output logic [5:0]                 dac_i_out,
    output logic [5:0]                 dac_q_out
);
    import rmo_pkg::*;

    // Software registers
    logic [7:0]     and_h_q;
    logic [6:0]     and_l_q;
    logic [7:0]     or_h_q;
    logic [6:0]     or_l_q;
    logic           vga_oe_q;
    logic [6:0]     vga_man_q;
    logic [1:0]     gm_ovr_q;
    logic           adc_clk_dis_q;
    rmo_dac_sel_t   dac_sel_q;
    logic [5:0]     dac_i_ovr_q;
    logic [5:0]     dac_q_ovr_q;

    // Effective controls
    logic [7:0]     eff_h_d;
    logic [7:0]     eff_h_q;
    logic [6:0]     eff_l_d;
    logic [7:0]     eff_l_w;
    logic [6:0]     eff_l_q;
    logic [6:0]     vga_gain_q;
    rmo_gain_mode_t gm_q;
    logic           adc_clk_en_q;
    logic [5:0]     dac_i_d;
    logic [5:0]     dac_q_d;
    logic [5:0]     dac_i_q;
    logic [5:0]     dac_q_q;

    // ADC sample synchronisers
    logic [6:0]     adc_i_m_q;
    logic [6:0]     adc_i_s_q;
    logic [6:0]     adc_q_m_q;
    logic [6:0]     adc_q_s_q;

    // Bus decode
    logic           setup;
    logic           wr_en;
    logic [15:0]    idx;
    logic           aligned;
    logic [7:0]     rd_val;
    logic           hit;
    logic [31:0]    prdata_q;
    logic           pslverr_q;
    logic [7:0]     wbyte;

    // Mask override of one control group
    function automatic logic [7:0] ovr(input logic [7:0] sig,
                                       input logic [7:0] am,
                                       input logic [7:0] om);
        ovr = (sig & am) | om;
    endfunction

    // True when the access addresses the given register index
    function automatic logic sel(input logic [15:0] i);
        sel = aligned && (idx == i);
    endfunction

    // Word index and alignment of the current access
    assign idx     = paddr_in[17:2];
    assign aligned = (paddr_in[1:0] == 2'h0);
    assign setup   = ce_in && psel_in && !penable_in;
    assign wr_en   = ce_in && psel_in && penable_in && pwrite_in && pstrb_in[0];
    assign wbyte   = pwdata_in[7:0];

    // Zero wait states; a stalled clock enable holds the access
    assign pready_out  = ce_in;
    assign prdata_out  = prdata_q;
    assign pslverr_out = pslverr_q;

    // Override mask registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            and_h_q <= `RMO_RST_AND_H;
            and_l_q <= `RMO_RST_AND_L;
            or_h_q  <= `RMO_RST_OR_H;
            or_l_q  <= `RMO_RST_OR_L;
        end else if (wr_en) begin
            if (sel(`RMO_IDX_AND_H)) begin
                and_h_q <= wbyte;
            end
            if (sel(`RMO_IDX_AND_L)) begin
                and_l_q <= wbyte[6:0];
            end
            if (sel(`RMO_IDX_OR_H)) begin
                or_h_q <= wbyte;
            end
            if (sel(`RMO_IDX_OR_L)) begin
                or_l_q <= wbyte[6:0];
            end
        end
    end

    // Gain override registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            vga_oe_q  <= 1'b0;
            vga_man_q <= `RMO_RST_VGA_GAIN;
            gm_ovr_q  <= 2'h0;
        end else if (wr_en) begin
            if (sel(`RMO_IDX_VGA)) begin
                vga_oe_q  <= wbyte[7];
                vga_man_q <= wbyte[6:0];
            end
            if (sel(`RMO_IDX_GAINMODE)) begin
                gm_ovr_q <= wbyte[3:2];
            end
        end
    end

    // ADC gate and DAC test registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            adc_clk_dis_q <= 1'b0;
            dac_sel_q     <= RMO_DAC_MOD;
            dac_i_ovr_q   <= 6'h00;
            dac_q_ovr_q   <= 6'h00;
        end else if (wr_en) begin
            if (sel(`RMO_IDX_ADC_I)) begin
                adc_clk_dis_q <= wbyte[7];
            end
            if (sel(`RMO_IDX_DAC_SEL)) begin
                dac_sel_q         <= rmo_dac_sel_t'(wbyte[6:4]);
                dac_i_ovr_q[5:2]  <= wbyte[3:0];
            end
            if (sel(`RMO_IDX_DAC_LO)) begin
                dac_i_ovr_q[1:0] <= wbyte[7:6];
                dac_q_ovr_q      <= wbyte[5:0];
            end
        end
    end

    // ADC samples cross from the converter, two flops each
    // Bits are not coherent across the word; good for test readback only
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            adc_i_m_q <= 7'h00;
            adc_i_s_q <= 7'h00;
            adc_q_m_q <= 7'h00;
            adc_q_s_q <= 7'h00;
        end else if (ce_in) begin
            adc_i_m_q <= adc_i_in;
            adc_i_s_q <= adc_i_m_q;
            adc_q_m_q <= adc_q_in;
            adc_q_s_q <= adc_q_m_q;
        end
    end

    // Effective control vectors
    always_comb begin
        eff_h_d = ovr(ctl_high_in, and_h_q, or_h_q);
        eff_l_w = ovr({1'b0, ctl_low_in}, {1'b0, and_l_q}, {1'b0, or_l_q});
        eff_l_d = eff_l_w[6:0];
    end

    // TX DAC source multiplexer
    // Test sources leave DAC power to software, through the override masks
    always_comb begin
        unique case (dac_sel_q)
            RMO_DAC_MOD: begin
                dac_i_d = mod_i_in;
                dac_q_d = mod_q_in;
            end
            RMO_DAC_OVR: begin
                dac_i_d = dac_i_ovr_q;
                dac_q_d = dac_q_ovr_q;
            end
            RMO_DAC_ADC_M: begin
                dac_i_d = adc_i_s_q[6:1];
                dac_q_d = adc_q_s_q[6:1];
            end
            RMO_DAC_FILT: begin
                dac_i_d = filt_i_in;
                dac_q_d = filt_q_in;
            end
            RMO_DAC_NOISE: begin
                dac_i_d = noise_i_in;
                dac_q_d = noise_q_in;
            end
            RMO_DAC_ADC_L: begin
                dac_i_d = adc_i_s_q[5:0];
                dac_q_d = adc_q_s_q[5:0];
            end
            RMO_DAC_RSSI: begin
                dac_i_d = rssi_mag_in;
                dac_q_d = 6'h00; // Magnitude has no Q part
            end
            RMO_DAC_DEBUG: begin
                dac_i_d = debug_i_in;
                dac_q_d = debug_q_in;
            end
        endcase
    end

    // Registered analog outputs, so no decode glitch reaches the radio
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            eff_h_q      <= 8'h00;
            eff_l_q      <= 7'h00;
            adc_clk_en_q <= 1'b0;
            dac_i_q      <= 6'h00;
            dac_q_q      <= 6'h00;
        end else if (ce_in) begin
            eff_h_q      <= eff_h_d;
            eff_l_q      <= eff_l_d;
            // ADC runs when powered, unless gated off
            adc_clk_en_q <= !eff_l_d[`RMO_L_ADC_OFF] && !adc_clk_dis_q;
            dac_i_q      <= dac_i_d;
            dac_q_q      <= dac_q_d;
        end
    end

    // Gain actually in use
    // Override code zero hands the mode choice back to the AGC
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            vga_gain_q <= `RMO_RST_VGA_GAIN;
            gm_q       <= RMO_GM_AGC;
        end else if (ce_in) begin
            vga_gain_q <= vga_oe_q ? vga_man_q : agc_vga_gain_in;
            gm_q       <= rmo_gain_mode_t'((gm_ovr_q != 2'h0) ? gm_ovr_q
                                                             : agc_gain_mode_in);
        end
    end

    // Low-byte control outputs
    assign filter_cal_osc_powerdown_out = eff_l_q[`RMO_L_CAL_PD];
    assign charge_pump_powerdown_out    = eff_l_q[`RMO_L_PUMP_OFF];
    assign synth_chain_powerdown_out    = eff_l_q[`RMO_L_SYN_PD];
    assign adc_powerdown_out            = eff_l_q[`RMO_L_ADC_OFF];
    assign vga_powerdown_out            = eff_l_q[`RMO_L_VGA_OFF];
    assign rx_filter_powerdown_out      = eff_l_q[`RMO_L_BPF_PD];
    assign front_end_powerdown_out      = eff_l_q[`RMO_L_FE_PD];

    // High-byte control outputs
    assign vga_peak_reset_n_out       = eff_h_q[`RMO_H_VGA_RST_N];
    assign global_bias_powerdown_out  = eff_h_q[`RMO_H_BIAS_OFF];
    assign output_switch_bias_ctl_out = eff_h_q[`RMO_H_SWITCH];
    assign buffer_select_out          = eff_h_q[`RMO_H_BUF_SEL];
    assign prescaler_powerdown_out    = eff_h_q[`RMO_H_PRESC_OFF];
    assign amp_neg_path_powerdown_out = eff_h_q[`RMO_H_AMP_N_OFF];
    assign amp_pos_path_powerdown_out = eff_h_q[`RMO_H_AMP_P_OFF];
    assign up_mixer_powerdown_out     = eff_h_q[`RMO_H_AMP_N_OFF] &
                                        eff_h_q[`RMO_H_AMP_P_OFF];
    assign tx_dac_powerdown_out       = eff_h_q[`RMO_H_DAC_PD];

    // Gain, clock gate and DAC outputs
    assign vga_gain_out   = vga_gain_q;
    assign gain_mode_out  = gm_q;
    assign adc_clk_en_out = adc_clk_en_q;
    assign dac_source_out = dac_sel_q;
    assign dac_i_out      = dac_i_q;
    assign dac_q_out      = dac_q_q;

    // Read value; reserved bits stay zero
    always_comb begin
        rd_val = 8'h00;
        hit    = 1'b1;
        unique case (1'b1)
            sel(`RMO_IDX_AND_H):    rd_val = and_h_q;
            sel(`RMO_IDX_AND_L):    rd_val = {1'b0, and_l_q};
            sel(`RMO_IDX_OR_H):     rd_val = or_h_q;
            sel(`RMO_IDX_OR_L):     rd_val = {1'b0, or_l_q};
            sel(`RMO_IDX_VGA):      rd_val = {vga_oe_q, vga_gain_q};
            sel(`RMO_IDX_GAINMODE): rd_val = {4'h0, gm_ovr_q, gm_q};
            sel(`RMO_IDX_FSM):      rd_val = {2'h0, frame_fsm_state_in};
            sel(`RMO_IDX_ADC_I):    rd_val = {adc_clk_dis_q, adc_i_s_q};
            sel(`RMO_IDX_ADC_Q):    rd_val = {1'b0, adc_q_s_q};
            sel(`RMO_IDX_DAC_SEL):  rd_val = {1'b0, dac_sel_q, dac_i_ovr_q[5:2]};
            sel(`RMO_IDX_DAC_LO):   rd_val = {dac_i_ovr_q[1:0], dac_q_ovr_q};
            default:                hit    = 1'b0;
        endcase
    end

    // Read data and error are captured in the setup cycle
    // so they stay steady however long a low clock enable stalls the access
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= pwrite_in ? 32'h0000_0000 : {24'h00_0000, rd_val};
            pslverr_q <= !hit;
        end
    end
endmodule

// >>> verilog/rmo_defs.svh
// Register indices, field positions and reset values of the radio override bank
`ifndef RMO_DEFS_SVH
`define RMO_DEFS_SVH

// Register indices; byte address is four times the index
`define RMO_IDX_AND_H     16'hdf22
`define RMO_IDX_AND_L     16'hdf23
`define RMO_IDX_OR_H      16'hdf24
`define RMO_IDX_OR_L      16'hdf25
`define RMO_IDX_VGA       16'hdf26
`define RMO_IDX_GAINMODE  16'hdf27
`define RMO_IDX_FSM       16'hdf39
`define RMO_IDX_ADC_I     16'hdf3a
`define RMO_IDX_ADC_Q     16'hdf3b
`define RMO_IDX_DAC_SEL   16'hdf3c
`define RMO_IDX_DAC_LO    16'hdf3d

// Reset values
`define RMO_RST_AND_H     8'hff
`define RMO_RST_AND_L     7'h7f
`define RMO_RST_OR_H      8'h00
`define RMO_RST_OR_L      7'h00
`define RMO_RST_VGA_GAIN  7'h7f

// High-byte control bits
`define RMO_H_VGA_RST_N   7
`define RMO_H_BIAS_OFF    6
`define RMO_H_SWITCH      5
`define RMO_H_BUF_SEL     4
`define RMO_H_PRESC_OFF   3
`define RMO_H_AMP_N_OFF   2
`define RMO_H_AMP_P_OFF   1
`define RMO_H_DAC_PD      0

// Low-byte control bits
`define RMO_L_CAL_PD      6
`define RMO_L_PUMP_OFF    5
`define RMO_L_SYN_PD      4
`define RMO_L_ADC_OFF     3
`define RMO_L_VGA_OFF     2
`define RMO_L_BPF_PD      1
`define RMO_L_FE_PD       0

`endif

// >>> verilog/rmo_pkg.sv
// Types shared by the radio override register bank
package rmo_pkg;
    // Source driving the TX DACs
    typedef enum logic [2:0] {
        RMO_DAC_MOD   = 3'h0,
        RMO_DAC_OVR   = 3'h1,
        RMO_DAC_ADC_M = 3'h2,
        RMO_DAC_FILT  = 3'h3,
        RMO_DAC_NOISE = 3'h4,
        RMO_DAC_ADC_L = 3'h5,
        RMO_DAC_RSSI  = 3'h6,
        RMO_DAC_DEBUG = 3'h7
    } rmo_dac_sel_t;
    // LNA/mixer gain mode; AGC code only valid as override
    typedef enum logic [1:0] {
        RMO_GM_AGC  = 2'h0,
        RMO_GM_LOW  = 2'h1,
        RMO_GM_MED  = 2'h2,
        RMO_GM_HIGH = 2'h3
    } rmo_gain_mode_t;
endpackage

// >>> dv/rmo_regs_monitor.sv
// Port checker for the radio override register bank
`timescale 1ns/1ps
module rmo_regs_monitor
    import rmo_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    input wire logic                    core_clk_in,
    input wire logic                    rst_in,
    input wire logic                    ce_in,
    input wire logic                    psel_in,
    input wire logic                    penable_in,
    input wire logic [5:0]              mod_i_in,
    input wire logic                    pready_out,
    input wire logic [31:0]             prdata_out,
    input wire logic                    pslverr_out,
    input wire logic                    amp_neg_path_powerdown_out,
    input wire logic                    amp_pos_path_powerdown_out,
    input wire logic                    up_mixer_powerdown_out,
    input wire logic                    adc_powerdown_out,
    input wire logic                    adc_clk_en_out,
    input wire logic [6:0]              vga_gain_out,
    input wire rmo_pkg::rmo_gain_mode_t gain_mode_out,
    input wire rmo_pkg::rmo_dac_sel_t   dac_source_out,
    input wire logic [5:0]              dac_i_out,
    input wire logic [5:0]              dac_q_out
);
    // One domain, so clock and reset are set once
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // Bus answer and read word shape
    ready_tracks_ce_a: assert property (pready_out == ce_in)
        else $error("pready does not follow clock enable");
    upper_zero_a: assert property (prdata_out[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    answer_at_setup_a: assert property (($changed(prdata_out) || $changed(pslverr_out))
        && !$past(rst_in) |-> $past(psel_in && !penable_in && ce_in))
        else $error("read data changed outside a setup edge");
    // Up-mixers follow both amplifier path power-downs
    up_mixer_both_a: assert property (up_mixer_powerdown_out
        == (amp_neg_path_powerdown_out && amp_pos_path_powerdown_out))
        else $error("up-mixer power-down not the and of both paths");
    // Either latency of the gate, a running clock means the ADC was up
    adc_gate_a: assert property (adc_clk_en_out && $past(adc_clk_en_out)
        && !$past(rst_in) |-> !$past(adc_powerdown_out))
        else $error("ADC clock runs while ADC powered down");
    mod_pass_a: assert property (!$past(rst_in) && $past(ce_in)
        && $past(dac_source_out) == RMO_DAC_MOD |-> dac_i_out == $past(mod_i_in))
        else $error("modulator source not on DAC I");
    rssi_q_zero_a: assert property (!$past(rst_in) && $past(ce_in)
        && $past(dac_source_out) == RMO_DAC_RSSI |-> dac_q_out == 6'h0)
        else $error("magnitude source leaves DAC Q nonzero");
    reset_release_a: assert property ($past(rst_in) && !rst_in |-> vga_gain_out == 7'h7f
        && gain_mode_out == RMO_GM_AGC && !adc_clk_en_out)
        else $error("outputs not at reset values after release");
    // Clock enable low must hold all state
    state_freeze_a: assert property (!$past(rst_in) && !$past(ce_in) |->
        $stable(vga_gain_out) && $stable(dac_i_out) && $stable(gain_mode_out))
        else $error("state moved while clock enable low");
endmodule

bind rmo_regs rmo_regs_monitor #(.ADDR_W(ADDR_W)) i_monitor (.*);

// >>> dv/tb_radio_manual_override_test_regs.sv
// Self-checking bench for the radio override register bank
`timescale 1ns/1ps
module tb_radio_manual_override_test_regs;
    import rmo_pkg::*;
    logic        core_clk_in, rst_in, ce_in, psel_in, penable_in, pwrite_in;
    logic        pready_out, pslverr_out, adc_clk_en_out, err;
    logic [17:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [31:0] seed = 32'hcff6;
    logic [3:0]  pstrb_in;
    logic [7:0]  ctl_high_in, am_h, am_l, om_h, om_l, vga, gm, dis, src, dlo;
    logic [6:0]  ctl_low_in, agc_vga_gain_in, adc_i_in, adc_q_in, vga_gain_out;
    logic [1:0]  agc_gain_mode_in;
    logic [5:0]  frame_fsm_state_in, mod_i_in, mod_q_in, filt_i_in, filt_q_in;
    logic [5:0]  noise_i_in, noise_q_in, rssi_mag_in, debug_i_in, debug_q_in;
    logic [5:0]  dac_i_out, dac_q_out;
    logic        filter_cal_osc_powerdown_out, charge_pump_powerdown_out;
    logic        synth_chain_powerdown_out, adc_powerdown_out, vga_powerdown_out;
    logic        rx_filter_powerdown_out, front_end_powerdown_out, vga_peak_reset_n_out;
    logic        global_bias_powerdown_out, output_switch_bias_ctl_out, buffer_select_out;
    logic        prescaler_powerdown_out, amp_neg_path_powerdown_out;
    logic        amp_pos_path_powerdown_out, up_mixer_powerdown_out, tx_dac_powerdown_out;
    rmo_gain_mode_t gain_mode_out;
    rmo_dac_sel_t   dac_source_out;
    int          n_mismatch = 0;
    int          n_tests = 0;
    // Two unmapped indices ride along with the real ones
    int regs[$] = '{16'hdf22, 16'hdf23, 16'hdf24, 16'hdf25, 16'hdf26, 16'hdf27,
                    16'hdf39, 16'hdf3a, 16'hdf3b, 16'hdf3c, 16'hdf3d, 16'hdf28, 16'hdf3e};

    rmo_regs i_dut (.*);

    // Free-running core clock
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Read value expected from the model state and live inputs
    function automatic logic [31:0] exp_rd(int i);
        logic [1:0] m;
        m = (gm[3:2] != 2'h0) ? gm[3:2] : agc_gain_mode_in;
        case (i)
            16'hdf22: return {24'h0, am_h};
            16'hdf23: return {24'h0, am_l};
            16'hdf24: return {24'h0, om_h};
            16'hdf25: return {24'h0, om_l};
            16'hdf26: return {24'h0, vga[7], vga[7] ? vga[6:0] : agc_vga_gain_in};
            16'hdf27: return {28'h0, gm[3:2], m};
            16'hdf39: return {26'h0, frame_fsm_state_in};
            16'hdf3a: return {24'h0, dis[7], adc_i_in};
            16'hdf3b: return {25'h0, adc_q_in};
            16'hdf3c: return {24'h0, src};
            16'hdf3d: return {24'h0, dlo};
            default: return 32'h0;
        endcase
    endfunction

    // Writable bits only; read-only and reserved bits never stored
    task automatic mdl_wr(int i, logic [7:0] d);
        case (i)
            16'hdf22: am_h = d;
            16'hdf23: am_l = d & 8'h7f;
            16'hdf24: om_h = d;
            16'hdf25: om_l = d & 8'h7f;
            16'hdf26: vga = d;
            16'hdf27: gm = d & 8'h0c;
            16'hdf3a: dis = d & 8'h80;
            16'hdf3c: src = d & 8'h7f;
            16'hdf3d: dlo = d;
            default: ;
        endcase
    endtask

    function automatic logic [11:0] exp_dac();
        case (src[6:4])
            3'h0: return {mod_i_in, mod_q_in};
            3'h1: return {src[3:0], dlo};
            3'h2: return {adc_i_in[6:1], adc_q_in[6:1]};
            3'h3: return {filt_i_in, filt_q_in};
            3'h4: return {noise_i_in, noise_q_in};
            3'h5: return {adc_i_in[5:0], adc_q_in[5:0]};
            3'h6: return {rssi_mag_in, 6'h0};
            default: return {debug_i_in, debug_q_in};
        endcase
    endfunction

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready however long it takes
    task automatic apb(logic w, int i, logic [7:0] d, logic [3:0] s);
        @(posedge core_clk_in);
        psel_in   <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in  <= 18'(i * 4);
        pwdata_in <= {24'h0, d};
        pstrb_in  <= s;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        do @(posedge core_clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in   <= 1'b0;
        penable_in <= 1'b0;
    endtask

    // New random values on every analog-side input
    task automatic stir();
        @(posedge core_clk_in);
        {ctl_high_in, ctl_low_in, agc_vga_gain_in, agc_gain_mode_in, frame_fsm_state_in}
            <= 30'(xs());
        {adc_i_in, adc_q_in, mod_i_in, mod_q_in} <= 26'(xs());
        {filt_i_in, filt_q_in, noise_i_in, noise_q_in, rssi_mag_in} <= 30'(xs());
        {debug_i_in, debug_q_in} <= 12'(xs());
    endtask

    task automatic check_all();
        logic [7:0] hi;
        logic [6:0] lo;
        hi = (ctl_high_in & am_h) | om_h;
        lo = (ctl_low_in & am_l[6:0]) | om_l[6:0];
        chk({filter_cal_osc_powerdown_out, charge_pump_powerdown_out, synth_chain_powerdown_out,
             adc_powerdown_out, vga_powerdown_out, rx_filter_powerdown_out,
             front_end_powerdown_out}, lo);
        chk({vga_peak_reset_n_out, global_bias_powerdown_out, output_switch_bias_ctl_out,
             buffer_select_out, prescaler_powerdown_out, amp_neg_path_powerdown_out,
             amp_pos_path_powerdown_out, tx_dac_powerdown_out}, hi);
        chk(up_mixer_powerdown_out, hi[2] & hi[1]);
        chk(vga_gain_out, vga[7] ? vga[6:0] : agc_vga_gain_in);
        chk(gain_mode_out, exp_rd(16'hdf27) & 32'h3);
        chk(adc_clk_en_out, !lo[3] && !dis[7]);
        chk(dac_source_out, src[6:4]);
        chk({dac_i_out, dac_q_out}, exp_dac());
        foreach (regs[k]) begin
            apb(1'b0, regs[k], 8'h0, 4'h0);
            chk(rd, exp_rd(regs[k]));
            chk(err, regs[k] inside {16'hdf28, 16'hdf3e});
        end
    endtask

    // Reset pulse; model returns to the register reset values
    task automatic do_reset();
        rst_in <= 1'b1;
        repeat (5) @(posedge core_clk_in);
        rst_in <= 1'b0;
        {am_h, am_l, om_h, om_l} = 32'hff7f0000;
        {vga, gm, dis, src, dlo} = 40'h7f00000000;
        repeat (2) @(posedge core_clk_in);
    endtask

    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, well beyond the few thousand cycles the run needs
    initial begin
        #(25 * 20000);
        n_mismatch++;
        conclude();
    end

    // Main sequence
    initial begin
        logic [7:0] d;
        logic [3:0] s;
        {rst_in, ce_in} = 2'b11;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, pstrb_in} = '0;
        {ctl_high_in, ctl_low_in, agc_vga_gain_in, agc_gain_mode_in, frame_fsm_state_in} = '0;
        {adc_i_in, adc_q_in, mod_i_in, mod_q_in, filt_i_in, filt_q_in} = '0;
        {noise_i_in, noise_q_in, rssi_mag_in, debug_i_in, debug_q_in} = '0;
        do_reset();
        check_all();
        $display("test reset_values done");
        // Every third pass drops the byte strobe, so its writes must not land
        for (int k = 0; k < 24; k++) begin
            stir();
            s = (k % 3 == 2) ? 4'he : 4'hf;
            foreach (regs[j]) begin
                d = 8'(xs());
                if (regs[j] == 16'hdf27) d[3:2] = k[1:0];
                if (regs[j] == 16'hdf3c) d[6:4] = k[2:0];
                // Test sources want the DACs powered by hand
                if (regs[j] inside {16'hdf22, 16'hdf24} && k[2:0] != 0) d[0] = 1'b0;
                apb(1'b1, regs[j], d, s);
                chk(err, regs[j] inside {16'hdf28, 16'hdf3e});
                if (s[0]) mdl_wr(regs[j], d);
            end
            @(posedge core_clk_in);
            ce_in <= 1'b0;
            stir();
            @(posedge core_clk_in);
            ce_in <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            check_all();
        end
        $display("test random_access done");
        do_reset();
        check_all();
        $display("test second_reset done");
        conclude();
    end
endmodule
